// ---- ccu_pkg.sv ----
/*
  Shared constants, types and the correction arithmetic of the
  conversion calibration unit.
  Assumes it is compiled before every file that imports it.
*/
package ccu_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int DATA_W  = 32;   // Main converter result.
  localparam int AUX_W   = 24;   // Auxiliary converter result.
  localparam int MCAL_W  = 24;   // Main calibration words.
  localparam int ACAL_W  = 16;   // Auxiliary calibration words.
  localparam int OFS_ALIGN = 8;  // Left shift placing an offset on top.
  localparam int AUX_PAD   = 8;  // Padding that lifts aux to main width.
  localparam int FIFO_DEPTH = 16;

  // ------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0] IDX_MOFS0 = 6'h07;
  localparam logic [5:0] IDX_MOFS1 = 6'h08;
  localparam logic [5:0] IDX_MOFS2 = 6'h09;
  localparam logic [5:0] IDX_MGAIN0 = 6'h0A;
  localparam logic [5:0] IDX_MGAIN1 = 6'h0B;
  localparam logic [5:0] IDX_MGAIN2 = 6'h0C;
  localparam logic [5:0] IDX_AOFS0 = 6'h17;
  localparam logic [5:0] IDX_AOFS1 = 6'h18;
  localparam logic [5:0] IDX_AGAIN0 = 6'h19;
  localparam logic [5:0] IDX_AGAIN1 = 6'h1A;
  localparam logic [5:0] IDX_CTRL = 6'h20;
  localparam logic [5:0] IDX_STAT = 6'h21;

  // Control and status field positions.
  localparam int CTRL_CHOP = 0;
  localparam int CTRL_CMD_LO = 1;
  localparam int CTRL_CMD_HI = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_MODE_LO = 1;
  localparam int STAT_MODE_HI = 2;
  localparam int STAT_CHOP = 3;
  localparam logic [1:0] CMD_SELF = 2'h1;
  localparam logic [1:0] CMD_SYS = 2'h2;

  // ------------------------------------------------------------------
  // Reset values and arithmetic constants
  // ------------------------------------------------------------------
  localparam logic [23:0] MOFS_RST = 24'h000000;
  localparam logic [23:0] MGAIN_RST = 24'h400000;
  localparam logic [15:0] AOFS_RST = 16'h0000;
  localparam logic [15:0] AGAIN_RST = 16'h4000;
  localparam int GAIN_SHIFT = 22;   // Divide by the main unity gain.
  localparam int CAL_SAMPLES = 16;
  localparam int CAL_SHIFT = 4;     // Log2 of the sample count.
  localparam logic [31:0] SAT_POS = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_NEG = 32'h80000000;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    CCU_IDLE = 2'b00,
    CCU_SELF = 2'b01,
    CCU_SYS  = 2'b10
  } ccu_state_t;

  // Offset removal, gain scaling and clipping on a 32-bit word.
  function automatic logic [31:0] ccu_correct(
    input logic [31:0] x,
    input logic [23:0] ofs,
    input logic [23:0] gain,
    input logic        skip_ofs
  );
    logic signed [33:0] diff;
    logic signed [58:0] prod;
    logic signed [58:0] scaled;
    diff = $signed({{2{x[31]}}, x});
    if (!skip_ofs) begin
      diff = diff - $signed({{2{ofs[23]}}, ofs, {OFS_ALIGN{1'b0}}});
    end
    prod = diff * $signed({1'b0, gain});
    scaled = prod >>> GAIN_SHIFT;
    if (scaled[58:31] == '0 || scaled[58:31] == '1) begin
      return scaled[31:0];
    end
    return scaled[58] ? SAT_NEG : SAT_POS;
  endfunction

endpackage

// ---- ccu_top.sv ----
/*
  Conversion calibration unit: result FIFO and the top level that
  corrects main and auxiliary filter output, holds the calibration
  words and runs the offset calibration commands.
  Assumes filter outputs arrive on hclk, a single AHB-Lite master and
  a clock enable that is high whenever the bus is used.
*/
// Functional notes
// - Main calibration words are 24 bits, auxiliary words 16 bits.
// - Main: subtract offset, scale by gain over 400000h, clip to 32 bits.
// - Main offset word is signed twos complement.
// - Main offset shifts left eight bits before subtraction.
// - Zero main offset at unity gain leaves the filter output unchanged.
// - Chop mode disables the stored main offset.
// - Main offset bytes sit at indexes 07h, 08h, 09h.
// - Aux offset aligned to the 24-bit result; bytes at 17h, 18h.
// - Main gain is unsigned, unity at 400000h.
// - Main gain bytes sit at indexes 0Ah, 0Bh, 0Ch.
// - Aux gain unsigned, unity 4000h; bytes at 19h, 1Ah.
// - Self-calibration shorts the amplifier, averages 16, loads offset.
// - System calibration averages 16 readings into the main offset.
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Synchronous FIFO with registered ready
// --------------------------------------------------------------------
module ccu_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock, reset and enable.
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Filling side.
  input  wire logic             s_valid,
  input  wire logic [WIDTH-1:0] s_data,
  output logic                  s_ready,
  // Draining side.
  output logic                  m_valid,
  output logic [WIDTH-1:0]      m_data,
  input  wire logic             m_ready
);
  localparam int AW = $clog2(DEPTH);

  // Elaboration check: the pointers rely on a power-of-two depth.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
    $error("ccu_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push = ce && s_valid && s_ready;
  assign pop = ce && m_valid && m_ready;
  assign m_valid = (count_reg != '0);
  assign m_data = mem[rd_ptr_reg];

  // Occupancy, computed once and shared by the count and ready flops.
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Ready is a flop so back-pressure reaches the source glitch free.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      s_ready <= 1'b1;
    end else if (ce) begin
      count_reg <= count_next;
      s_ready <= (count_next != (AW+1)'(DEPTH));
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // Storage has no reset; it is only read where count says valid.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= s_data;
    end
  end
endmodule

// --------------------------------------------------------------------
// Top level
// --------------------------------------------------------------------
module ccu_top (
  // Clock, reset and enable.
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      ce,
  // AHB-Lite slave.
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic [31:0]                    hrdata,
  output logic                           hresp,
  // Main filter output.
  input  wire logic                      main_valid,
  input  wire logic [ccu_pkg::DATA_W-1:0] main_data,
  output logic                           main_ready,
  // Corrected main result.
  output logic                           res_valid,
  output logic [ccu_pkg::DATA_W-1:0]     res_data,
  input  wire logic                      res_ready,
  // Auxiliary filter output and its corrected result.
  input  wire logic                      aux_valid,
  input  wire logic [ccu_pkg::AUX_W-1:0] aux_data,
  output logic                           aux_res_valid,
  output logic [ccu_pkg::AUX_W-1:0]      aux_res_data,
  // Calibration status towards the analog front end.
  output logic                           amp_short,
  output logic                           cal_busy
);
  import ccu_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [MCAL_W-1:0] mofs_reg;
  logic [MCAL_W-1:0] mgain_reg;
  logic [ACAL_W-1:0] aofs_reg;
  logic [ACAL_W-1:0] again_reg;
  logic              chop_reg;
  ccu_state_t        state_reg;
  logic [3:0]        cal_cnt_reg;
  logic [35:0]       cal_sum_reg;
  logic [35:0]       cal_sum_next;
  logic              cal_load;
  logic [MCAL_W-1:0] cal_word;
  logic              dp_wr_reg;
  logic [5:0]        dp_idx_reg;
  logic              addr_ok;
  logic [5:0]        a_idx;
  logic [31:0]       rd_value;
  logic              accept;
  logic              fifo_s_valid;
  logic [31:0]       fifo_s_data;
  logic              fifo_m_valid;
  logic [31:0]       fifo_m_data;
  logic              fifo_m_ready;
  logic [31:0]       aux_full;

  // ------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ------------------------------------------------------------------
  assign a_idx = haddr[7:2];
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ)
                   && (haddr[31:8] == '0);

  // Address phase of a word write is held for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_idx_reg <= '0;
    end else if (ce) begin
      dp_wr_reg <= addr_ok && hwrite && (hsize == HSIZE_WORD);
      dp_idx_reg <= a_idx;
    end
  end

  // Read mux; unmapped indexes and reserved bits read as zero.
  always_comb begin
    rd_value = '0;
    unique case (a_idx)
      IDX_MOFS0:  rd_value[7:0] = mofs_reg[7:0];
      IDX_MOFS1:  rd_value[7:0] = mofs_reg[15:8];
      IDX_MOFS2:  rd_value[7:0] = mofs_reg[23:16];
      IDX_MGAIN0: rd_value[7:0] = mgain_reg[7:0];
      IDX_MGAIN1: rd_value[7:0] = mgain_reg[15:8];
      IDX_MGAIN2: rd_value[7:0] = mgain_reg[23:16];
      IDX_AOFS0:  rd_value[7:0] = aofs_reg[7:0];
      IDX_AOFS1:  rd_value[7:0] = aofs_reg[15:8];
      IDX_AGAIN0: rd_value[7:0] = again_reg[7:0];
      IDX_AGAIN1: rd_value[7:0] = again_reg[15:8];
      IDX_CTRL:   rd_value[CTRL_CHOP] = chop_reg;
      IDX_STAT: begin
        rd_value[STAT_BUSY] = (state_reg != CCU_IDLE);
        rd_value[STAT_MODE_HI:STAT_MODE_LO] = state_reg;
        rd_value[STAT_CHOP] = chop_reg;
      end
      default: rd_value = '0;
    endcase
  end

  // Read data is captured in the address phase so it stands in the data
  // phase; the cost is that a read right after a write sees old data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

  // ------------------------------------------------------------------
  // Calibration words
  // ------------------------------------------------------------------
  // A finishing calibration wins over a bus write in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mofs_reg <= MOFS_RST;
    end else if (ce) begin
      if (cal_load) begin
        mofs_reg <= cal_word;
      end else if (dp_wr_reg) begin
        unique case (dp_idx_reg)
          IDX_MOFS0: mofs_reg[7:0] <= hwdata[7:0];
          IDX_MOFS1: mofs_reg[15:8] <= hwdata[7:0];
          IDX_MOFS2: mofs_reg[23:16] <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Gain and auxiliary words change only from the bus.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mgain_reg <= MGAIN_RST;
      aofs_reg <= AOFS_RST;
      again_reg <= AGAIN_RST;
      chop_reg <= 1'b0;
    end else if (ce && dp_wr_reg) begin
      unique case (dp_idx_reg)
        IDX_MGAIN0: mgain_reg[7:0] <= hwdata[7:0];
        IDX_MGAIN1: mgain_reg[15:8] <= hwdata[7:0];
        IDX_MGAIN2: mgain_reg[23:16] <= hwdata[7:0];
        IDX_AOFS0: aofs_reg[7:0] <= hwdata[7:0];
        IDX_AOFS1: aofs_reg[15:8] <= hwdata[7:0];
        IDX_AGAIN0: again_reg[7:0] <= hwdata[7:0];
        IDX_AGAIN1: again_reg[15:8] <= hwdata[7:0];
        IDX_CTRL: chop_reg <= hwdata[CTRL_CHOP];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Offset calibration sequencer
  // ------------------------------------------------------------------
  // Raw samples are summed; the host has prepared the inputs.
  assign accept = ce && main_valid && main_ready;
  assign cal_sum_next = cal_sum_reg + {{4{main_data[31]}}, main_data};
  assign cal_load = accept && (state_reg != CCU_IDLE)
                    && (cal_cnt_reg == 4'(CAL_SAMPLES - 1));
  // Average is the sum over 16; its top 24 bits align as an offset.
  assign cal_word = cal_sum_next[CAL_SHIFT+OFS_ALIGN +: MCAL_W];

  // Commands arriving while busy are ignored.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= CCU_IDLE;
      cal_cnt_reg <= '0;
      cal_sum_reg <= '0;
    end else if (ce) begin
      unique case (state_reg)
        CCU_IDLE: begin
          cal_cnt_reg <= '0;
          cal_sum_reg <= '0;
          if (dp_wr_reg && dp_idx_reg == IDX_CTRL) begin
            if (hwdata[CTRL_CMD_HI:CTRL_CMD_LO] == CMD_SELF) begin
              state_reg <= CCU_SELF;
            end else if (hwdata[CTRL_CMD_HI:CTRL_CMD_LO] == CMD_SYS) begin
              state_reg <= CCU_SYS;
            end
          end
        end
        CCU_SELF, CCU_SYS: begin
          if (accept) begin
            cal_sum_reg <= cal_sum_next;
            cal_cnt_reg <= cal_cnt_reg + 1'b1;
          end
          if (cal_load) begin
            state_reg <= CCU_IDLE;
          end
        end
        default: state_reg <= CCU_IDLE;
      endcase
    end
  end

  // The amplifier short follows the self-calibration state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      amp_short <= 1'b0;
      cal_busy <= 1'b0;
    end else if (ce) begin
      amp_short <= (state_reg == CCU_SELF) && !cal_load;
      cal_busy <= (state_reg != CCU_IDLE) && !cal_load;
    end
  end

  // ------------------------------------------------------------------
  // Main correction path and result FIFO
  // ------------------------------------------------------------------
  // Samples taken for calibration are not passed on.
  assign fifo_s_valid = main_valid && (state_reg == CCU_IDLE);
  // Offset is signed and shifted up; chop bypasses it.
  assign fifo_s_data = ccu_correct(main_data, mofs_reg, mgain_reg,
                                   chop_reg);
  assign fifo_m_ready = !res_valid || res_ready;

  ccu_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (hclk),
    .rst_n   (hresetn),
    .ce      (ce),
    .s_valid (fifo_s_valid),
    .s_data  (fifo_s_data),
    .s_ready (main_ready),
    .m_valid (fifo_m_valid),
    .m_data  (fifo_m_data),
    .m_ready (fifo_m_ready)
  );

  // Output register so the result ports come straight from flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_valid <= 1'b0;
      res_data <= '0;
    end else if (ce && fifo_m_ready) begin
      res_valid <= fifo_m_valid;
      if (fifo_m_valid) begin
        res_data <= fifo_m_data;
      end
    end
  end

  // ------------------------------------------------------------------
  // Auxiliary correction path
  // ------------------------------------------------------------------
  // Padding by eight bits reuses the main arithmetic: the offset lands
  // on the top of the 24-bit result and the gain divides by 4000h.
  assign aux_full = ccu_correct({aux_data, {AUX_PAD{1'b0}}},
                                {aofs_reg, {AUX_PAD{1'b0}}},
                                {again_reg, {AUX_PAD{1'b0}}},
                                1'b0);

  // The aux path has no back-pressure; each sample gives one pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_res_valid <= 1'b0;
      aux_res_data <= '0;
    end else if (ce) begin
      aux_res_valid <= aux_valid;
      if (aux_valid) begin
        aux_res_data <= aux_full[DATA_W-1 -: AUX_W];
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_zero_ofs;
    fifo_s_valid && mofs_reg == '0 && mgain_reg == MGAIN_RST
      |-> fifo_s_data == main_data;
  endproperty
  a_zero_ofs: assert property (p_zero_ofs)
    else $error("zero offset changed the sample");

  property p_chop;
    fifo_s_valid && chop_reg && mgain_reg == MGAIN_RST
      |-> fifo_s_data == main_data;
  endproperty
  a_chop: assert property (p_chop)
    else $error("offset applied in chop mode");

  // The most negative offset overflows the negation and must clip.
  property p_align;
    fifo_s_valid && !chop_reg && main_data == '0
      && mgain_reg == MGAIN_RST
      |-> fifo_s_data == ((mofs_reg == 24'h800000) ? SAT_POS
                          : 32'(-$signed({mofs_reg, 8'h00})));
  endproperty
  a_align: assert property (p_align)
    else $error("offset not aligned to the upper bits");

  property p_sat;
    fifo_s_valid && !chop_reg && mofs_reg == '0
      && mgain_reg >= 24'h800000 && main_data == SAT_POS
      |-> fifo_s_data == SAT_POS;
  endproperty
  a_sat: assert property (p_sat)
    else $error("main result wrapped instead of saturating");

  property p_cal_load;
    cal_load && ce |=> mofs_reg == $past(cal_word) && !cal_busy;
  endproperty
  a_cal_load: assert property (p_cal_load)
    else $error("calibration average not loaded");

  property p_cal_count;
    accept && state_reg != CCU_IDLE && !cal_load
      |=> cal_cnt_reg == 4'($past(cal_cnt_reg) + 4'h1);
  endproperty
  a_cal_count: assert property (p_cal_count)
    else $error("calibration counted too many samples");

  property p_short;
    ce && state_reg == CCU_SELF && !cal_load |=> amp_short;
  endproperty
  a_short: assert property (p_short)
    else $error("amplifier not shorted during self calibration");

  property p_mofs_wr;
    ce && dp_wr_reg && dp_idx_reg == IDX_MOFS1 && !cal_load
      |=> mofs_reg[15:8] == $past(hwdata[7:0]);
  endproperty
  a_mofs_wr: assert property (p_mofs_wr)
    else $error("middle offset byte not written");

  property p_gain_rd;
    ce && addr_ok && !hwrite && a_idx == IDX_MGAIN2
      |=> hrdata == {24'h0, $past(mgain_reg[23:16])};
  endproperty
  a_gain_rd: assert property (p_gain_rd)
    else $error("high gain byte read back wrong");

  property p_aux_unity;
    ce && aux_valid && aofs_reg == '0 && again_reg == AGAIN_RST
      |=> aux_res_valid && aux_res_data == $past(aux_data);
  endproperty
  a_aux_unity: assert property (p_aux_unity)
    else $error("aux unity correction changed the sample");

  c_self_done: cover property (cal_load && state_reg == CCU_SELF);
  c_sys_done: cover property (cal_load && state_reg == CCU_SYS);
  c_fifo_full: cover property (!main_ready && main_valid);
  c_saturate: cover property (fifo_s_valid && fifo_s_data == SAT_NEG);
endmodule

// ---- ccu_host.sv ----
/*
  Host model: a single AHB-Lite master that writes and reads the
  calibration registers and issues offset calibration commands.
  Assumes one slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Host bus master
// ------------------------------------------------------------------
module ccu_host (
  // Bus.
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  import ccu_pkg::*;
  // The bus idles until the first transfer; only word transfers occur.
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
  end
  // One transfer; each phase is held until hready is seen high.
  task automatic xfer(input logic w, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Offset commands only, after the inputs are set up; never full-scale.
  task automatic cal_cmd(input logic [1:0] cmd);
    logic [31:0] d;
    xfer(1'b1, IDX_CTRL, {29'h0, cmd, 1'b0}, d);
  endtask
endmodule

// ---- conversion_calibration_unit_bench.sv ----
/*
  Self-checking bench of the calibration unit: registers, main and aux
  correction, result FIFO and offset calibration.
  Assumes ccu_pkg, ccu_top and the host model are compiled first.
*/
`timescale 1ns/1ps
module conversion_calibration_unit_bench;
  import ccu_pkg::*;
  logic        hclk = 1'b0, hresetn, hready, hreadyout, hresp, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, main_data, res_data, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        main_valid, main_ready, res_valid, res_ready, aux_valid;
  logic        aux_res_valid, amp_short, cal_busy;
  logic [23:0] aux_data, aux_res_data;
  int          errors = 0, n_tests = 0, cyc = 0;
  // Clock of 100 ns; the one slave answers its own bus.
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  ccu_top dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .main_valid(main_valid),
    .main_data(main_data), .main_ready(main_ready), .res_valid(res_valid),
    .res_data(res_data), .res_ready(res_ready), .aux_valid(aux_valid),
    .aux_data(aux_data), .aux_res_valid(aux_res_valid),
    .aux_res_data(aux_res_data), .amp_short(amp_short), .cal_busy(cal_busy));
  ccu_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d, rd);
  endtask
  task automatic rchk(input string s, input logic [5:0] i, logic [31:0] e);
    host.xfer(1'b0, i, 32'h0, rd);
    chk(s, e, rd);
  endtask
  // Valid is held until an edge that sees ready high.
  task automatic send(input logic [31:0] x);
    @(posedge hclk);
    main_valid <= 1'b1;
    main_data <= x;
    do @(posedge hclk); while (main_ready !== 1'b1);
    main_valid <= 1'b0;
  endtask
  task automatic get(input logic [31:0] e);
    do @(posedge hclk); while (res_valid !== 1'b1);
    chk("res_data", e, res_data);
  endtask
  task automatic set_main(input logic [23:0] o, g, input logic chop);
    for (int i = 0; i < 3; i++) begin
      wr(6'(IDX_MOFS0 + i), 32'(o >> (8 * i)));
      wr(6'(IDX_MGAIN0 + i), 32'(g >> (8 * i)));
    end
    wr(IDX_CTRL, {31'h0, chop});
  endtask
  // Reset values, an unmapped place and reserved bits.
  task automatic t_regs();
    logic [5:0] ix [10] = '{6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C,
                            6'h17, 6'h18, 6'h19, 6'h1A};
    for (int i = 0; i < 10; i++)
      rchk("reset", ix[i], (i == 5 || i == 9) ? 32'h40 : 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    wr(6'h3F, 32'hFFFFFFFF);
    rchk("unmapped", 6'h3F, 32'h0);
    wr(IDX_CTRL, 32'h7);
    rchk("ctrl chop", IDX_CTRL, 32'h1);
    wr(IDX_AGAIN1, 32'h12345640);
    rchk("aux gain high", IDX_AGAIN1, 32'h40);
  endtask
  // Offset, chop, gain and clipping cases: offset, gain, chop, in, out.
  task automatic t_main();
    logic [31:0] tv [9][5] = '{
      '{0, 32'h400000, 0, 32'h12345678, 32'h12345678},
      '{1, 32'h400000, 0, 0, 32'hFFFFFF00},
      '{32'hFFFFFF, 32'h400000, 0, 0, 32'h00000100},
      '{1, 32'h400000, 1, 0, 0},
      '{0, 32'h433333, 0, 32'h10000000, 32'h10CCCCC0},
      '{0, 32'h3CCCCC, 0, 32'h10000000, 32'h0F333300},
      '{0, 32'h800000, 0, 32'h7FFFFFFF, 32'h7FFFFFFF},
      '{0, 32'h800000, 0, 32'h80000000, 32'h80000000},
      '{32'h800000, 32'h400000, 0, 0, 32'h7FFFFFFF}};
    for (int i = 0; i < 9; i++) begin
      set_main(tv[i][0][23:0], tv[i][1][23:0], tv[i][2][0]);
      send(tv[i][3]);
      get(tv[i][4]);
    end
  endtask
  // Fill output register and FIFO with the far side stalled, then drain.
  task automatic t_fifo();
    set_main(24'h000000, 24'h400000, 1'b0);
    res_ready <= 1'b0;
    for (int i = 0; i <= FIFO_DEPTH; i++) send(32'(i));
    @(posedge hclk);
    chk("main_ready full", 32'h0, {31'h0, main_ready});
    res_ready <= 1'b1;
    for (int i = 0; i <= FIFO_DEPTH; i++) get(32'(i));
    @(posedge hclk);
    chk("res_valid empty", 32'h0, {31'h0, res_valid});
  endtask
  // Aux cases: offset, gain, input and expected 24-bit result.
  task automatic t_aux();
    logic [23:0] av [4][4] = '{'{1, 24'h4000, 0, 24'hFFFF00},
      '{0, 24'h8000, 24'h7FFFFF, 24'h7FFFFF},
      '{0, 24'h2000, 24'h200000, 24'h100000},
      '{0, 24'h4000, 24'h876543, 24'h876543}};
    for (int i = 0; i < 4; i++) begin
      wr(IDX_AOFS0, 32'(av[i][0]));
      wr(IDX_AOFS1, 32'(av[i][0] >> 8));
      wr(IDX_AGAIN0, 32'(av[i][1]));
      wr(IDX_AGAIN1, 32'(av[i][1] >> 8));
      @(posedge hclk);
      aux_valid <= 1'b1;
      aux_data <= av[i][2];
      @(posedge hclk);
      aux_valid <= 1'b0;
      @(posedge hclk);
      chk("aux_res_valid", 32'h1, {31'h0, aux_res_valid});
      chk("aux_res_data", 32'(av[i][3]), 32'(aux_res_data));
    end
  endtask
  // Sixteen equal samples are averaged into the main offset word.
  task automatic t_cal(input logic [1:0] c, input logic [31:0] x,
                       input logic [23:0] e, input logic sh);
    host.cal_cmd(c);
    repeat (2) @(posedge hclk);
    chk("busy", 32'h1, {31'h0, cal_busy});
    chk("amp_short", {31'h0, sh}, {31'h0, amp_short});
    for (int i = 0; i < CAL_SAMPLES; i++) send(x);
    repeat (2) @(posedge hclk);
    chk("busy done", 32'h0, {31'h0, cal_busy | res_valid});
    for (int i = 0; i < 3; i++)
      rchk("cal offset", 6'(IDX_MOFS0 + i), 32'(e[8*i+:8]));
  endtask
  // Inputs idle at time zero; reset held for six cycles.
  initial begin
    hresetn = 1'b0;
    main_valid = 1'b0;
    main_data = 32'h0;
    res_ready = 1'b1;
    aux_valid = 1'b0;
    aux_data = 24'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_main();
    t_fifo();
    t_aux();
    t_cal(CMD_SELF, 32'h00001200, 24'h000012, 1'b1);
    t_cal(CMD_SYS, 32'hFFFFFF00, 24'hFFFFFF, 1'b0);
    give_verdict();
  end
  // The run needs well under a thousand cycles; a hang ends at cycle 20000.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
endmodule
